// ===== hdl/wrc_pkg.sv
// Purpose: shared constants and types for the watchdog and reset control block
// Assumes: 200 MHz system clock, 32-bit classic wishbone register access
// Notes: every offset, reset value and cycle count lives here

package wrc_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_NS = 5; // 200 MHz period
    localparam int SRESET_NS = 1000; // software-reset delay, ns
    localparam int LV_FILTER_NS = 120000; // low-supply filter time, ns
    // least times round up to whole cycles
    localparam logic [15:0] SRESET_CYC = 16'((SRESET_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] LV_FILTER_CYC = 16'((LV_FILTER_NS + CLK_NS - 1) / CLK_NS);

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] OFS_WATCHDOG_CONTROL = 4'h0; // watchdog_control
    localparam logic [3:0] OFS_FLAGS = 4'h4; // reset_cause_flags
    localparam logic [3:0] OFS_LOW_VOLTAGE_CONTROL = 4'h8; // low_voltage_control
    localparam logic [3:0] OFS_STAT = 4'hc; // status, read only

    // ----------------------------------------
    // field layout and values
    // ----------------------------------------
    localparam logic [7:0] WATCHDOG_CONTROL_POR = 8'h53; // key enable, longest-but-4 timeout
    localparam logic [7:0] LOW_VOLTAGE_CONTROL_POR = 8'h5a;
    localparam logic [7:0] LV_KEY_ON = 8'h5a; // low-voltage reset armed
    localparam logic [7:0] LV_KEY_OFF = 8'ha5; // low-voltage reset off
    localparam logic [4:0] WKEY_ON = 5'h0a; // watchdog enabled
    localparam logic [4:0] WKEY_OFF = 5'h15; // watchdog disabled
    localparam int WKEY_LSB = 3; // key field bits 7..3
    localparam int WSEL_BASE = 8; // code 0 gives 2^8 ticks
    localparam int FLG_WKF = 0; // flag bit positions
    localparam int FLG_LKF = 1;
    localparam int FLG_LVF = 2;
    localparam int ST_TO = 0; // status bit positions
    localparam int ST_PD = 1;
    localparam int ST_WEN = 2;
    localparam int ST_LEN = 3;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic {
        SR_IDLE = 1'b0, // no key fault pending
        SR_DELAY = 1'b1 // counting down the software-reset delay
    } wrc_srst_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr; // byte address, bits 1..0 ignored
        logic [31:0] dat;
    } wrc_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wrc_wb_rsp_t;

    typedef struct packed {
        logic clear_watchdog_instruction; // one-cycle pulse: clear-watchdog instruction
        logic halt; // one-cycle pulse: halt instruction
        logic sleep; // level: core in sleep or idle
    } wrc_cpu_t;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stab;
    } wrc_sync_t;

    typedef struct packed {
        logic [7:0] watchdog_control;
        logic [7:0] low_voltage_control;
        logic wkf;
        logic lkf;
        logic lvf;
        logic to_flag;
        logic pd_flag;
        logic [15:0] wcnt;
        logic [15:0] lvcnt;
        logic [15:0] srcnt;
        wrc_srst_t srst;
        logic pend_w;
        logic pend_l;
        logic osc_prev;
        logic ack;
        logic [31:0] rdata;
        logic dev_rst;
        logic pc_clr;
        logic port_pre;
    } wrc_state_t;

    localparam wrc_sync_t SYNC_POR = '{default: '0};
    localparam wrc_state_t ST_POR = '{watchdog_control: WATCHDOG_CONTROL_POR, low_voltage_control: LOW_VOLTAGE_CONTROL_POR, srst: SR_IDLE,
                                      pc_clr: 1'b1, port_pre: 1'b1, default: '0};

endpackage

// ===== hdl/wrc_sync.sv
// Purpose: two-flop synchroniser for the slow oscillator and the supply pin
// Assumes: inputs are asynchronous to clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps

module wrc_sync
    import wrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);

    wrc_sync_t sync_reg; // both stages
    wrc_sync_t sync_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        sync_next = sync_reg;
        sync_next.meta = async_in;
        sync_next.stab = sync_reg.meta;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_reg <= SYNC_POR;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.stab;

endmodule

// ===== hdl/wrc_top.sv
// Purpose: watchdog timer, keyed low-voltage control and reset-cause flags
// Assumes: rst_b is the power-on reset; cpu strobes are on clk
// Notes: registers sit on a classic wishbone slave, one byte per word
//
// Overview of operation
// - watchdog counts only slow oscillator edges
// - timeout select gives 2^8 to 2^15 ticks
// - key 10101 disables, 01010 enables watchdog
// - bad watchdog key resets after delay, flags
// - watchdog key powers up as enable pattern
// - watchdog key fault flag sticky, software clears
// - unused upper flag bits read zero
// - running overflow gives full reset, timeout flag
// - sleep overflow sets flag, clears pc, sp
// - bad key, clear, halt zero the counter
// - power-on reset zeroes program counter
// - power-on reset presets ports as inputs
// - low supply must outlast filter time
// - lv key 5a arms, a5 disarms reset
// - bad lv key resets after delay, flags
// - bad lv key reset restores lv register
// - real low-supply reset keeps lv register
// - lv key powers up as enable pattern
// - sleep or idle suspends low-voltage reset
// - low-voltage flag sticky, software clears
// - halt clears counter, runs on if enabled
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps

module wrc_top
    import wrc_pkg::*;
#(
    parameter logic [15:0] LV_FILTER_CYCLES = LV_FILTER_CYC // shorten in simulation
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic slow_osc_clock,
    input wire logic lv_low,
    input wire wrc_cpu_t cpu,
    input wire wrc_wb_req_t wb_req,
    output wrc_wb_rsp_t wb_rsp,
    output logic device_reset,
    output logic pc_sp_clear,
    output logic port_preset,
    output logic timeout_status_flag,
    output logic power_down_flag
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // terminal count for a timeout select code
    function automatic logic [15:0] wdt_limit(input logic [2:0] sel);
        logic [31:0] full;
        full = (32'h1 << (WSEL_BASE + int'(sel))) - 32'h1;
        wdt_limit = full[15:0];
    endfunction

    // byte register placed in the low lane
    function automatic logic [31:0] byte_rd(input logic [7:0] v);
        byte_rd = {24'h0, v};
    endfunction

    // ----------------------------------------
    // state and synchronised pins
    // ----------------------------------------
    wrc_state_t s_reg; // all block state
    wrc_state_t s_next;
    logic [1:0] pin_sync; // [0] slow osc, [1] supply low
    logic osc_sync;
    logic low_sync;
    logic [4:0] wkey; // watchdog key field
    logic wdt_on; // key says enabled
    logic wdt_bad; // key is neither pattern
    logic lv_bad; // lv key is neither pattern
    logic lv_armed; // lv reset active now
    logic osc_tick; // one slow clock rising edge
    logic wdt_expire; // counter overflow this cycle
    logic bus_req; // request waiting for ack
    logic bus_wr; // write takes effect now

    wrc_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({lv_low, slow_osc_clock}),
        .sync_out(pin_sync)
    );

    assign osc_sync = pin_sync[0];
    assign low_sync = pin_sync[1];

    // ----------------------------------------
    // decode of current state
    // ----------------------------------------
    assign wkey = s_reg.watchdog_control[WKEY_LSB +: 5];
    assign wdt_on = (wkey == WKEY_ON);
    assign wdt_bad = (wkey != WKEY_ON) && (wkey != WKEY_OFF);
    assign lv_bad = (s_reg.low_voltage_control != LV_KEY_ON) && (s_reg.low_voltage_control != LV_KEY_OFF);
    // sleep or idle parks the supply monitor
    assign lv_armed = (s_reg.low_voltage_control == LV_KEY_ON) && !cpu.sleep;
    // the counter sees only slow oscillator edges
    assign osc_tick = osc_sync && !s_reg.osc_prev;
    // an instruction clear in the same cycle beats the overflow
    assign wdt_expire = wdt_on && osc_tick && !cpu.clear_watchdog_instruction && !cpu.halt &&
                        (s_reg.wcnt == wdt_limit(s_reg.watchdog_control[2:0]));
    assign bus_req = wb_req.cyc && wb_req.stb;
    // writes land on the edge at which the master sees ack
    assign bus_wr = bus_req && wb_req.we && s_reg.ack;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        logic full_rst; // whole-device reset this cycle
        logic keep_lv; // lv register survives this reset
        full_rst = 1'b0;
        keep_lv = 1'b0;
        s_next = s_reg;
        s_next.dev_rst = 1'b0;
        s_next.pc_clr = 1'b0;
        s_next.port_pre = 1'b0;
        s_next.osc_prev = osc_sync;

        // bus slave: single-wait ack, dropped the cycle after
        s_next.ack = bus_req && !s_reg.ack;
        s_next.rdata = 32'h0;
        if (bus_req && !wb_req.we && !s_reg.ack) begin
            unique case ({wb_req.adr[3:2], 2'b00})
                OFS_WATCHDOG_CONTROL: begin
                    s_next.rdata = byte_rd(s_reg.watchdog_control);
                end
                OFS_FLAGS: begin
                    // upper bits stay zero
                    s_next.rdata = byte_rd({5'h0, s_reg.lvf, s_reg.lkf, s_reg.wkf});
                end
                OFS_LOW_VOLTAGE_CONTROL: begin
                    s_next.rdata = byte_rd(s_reg.low_voltage_control);
                end
                OFS_STAT: begin
                    s_next.rdata = byte_rd({4'h0, lv_armed, wdt_on,
                                            s_reg.pd_flag, s_reg.to_flag});
                end
            endcase
        end
        if (bus_wr && wb_req.sel[0]) begin
            unique case ({wb_req.adr[3:2], 2'b00})
                OFS_WATCHDOG_CONTROL: begin
                    s_next.watchdog_control = wb_req.dat[7:0];
                end
                OFS_FLAGS: begin
                    // software may only clear: a written zero clears, a one keeps
                    s_next.wkf = s_reg.wkf & wb_req.dat[FLG_WKF];
                    s_next.lkf = s_reg.lkf & wb_req.dat[FLG_LKF];
                    s_next.lvf = s_reg.lvf & wb_req.dat[FLG_LVF];
                end
                OFS_LOW_VOLTAGE_CONTROL: begin
                    s_next.low_voltage_control = wb_req.dat[7:0];
                end
                default: begin
                    // status is read only, nothing to store
                end
            endcase
        end

        // instruction side effects on the power-down and timeout flags
        if (cpu.halt) begin
            s_next.pd_flag = 1'b1;
            s_next.to_flag = 1'b0;
        end else if (cpu.clear_watchdog_instruction) begin
            s_next.pd_flag = 1'b0;
            s_next.to_flag = 1'b0;
        end

        // watchdog counter
        if (!wdt_on) begin
            s_next.wcnt = 16'h0;
        end else if (cpu.clear_watchdog_instruction || cpu.halt) begin
            // cleared, and keeps counting since still enabled
            s_next.wcnt = 16'h0;
        end else if (wdt_expire) begin
            s_next.wcnt = 16'h0;
        end else if (osc_tick) begin
            s_next.wcnt = 16'(s_reg.wcnt + 16'h1);
        end

        // supply monitor filter: short dips restart the count
        if (lv_armed && low_sync) begin
            if (s_reg.lvcnt == LV_FILTER_CYCLES) begin
                s_next.lvcnt = 16'h0;
                s_next.lvf = 1'b1;
                full_rst = 1'b1;
                keep_lv = 1'b1;
            end else begin
                s_next.lvcnt = 16'(s_reg.lvcnt + 16'h1);
            end
        end else begin
            s_next.lvcnt = 16'h0;
        end

        // overflow: wake-style reset in sleep, full reset otherwise
        if (wdt_expire) begin
            s_next.to_flag = 1'b1;
            if (cpu.sleep) begin
                s_next.pc_clr = 1'b1;
            end else begin
                full_rst = 1'b1;
                keep_lv = 1'b0;
            end
        end

        // key-fault sequencer, causes collected during the delay
        unique case (s_reg.srst)
            SR_IDLE: begin
                if (wdt_bad || lv_bad) begin
                    s_next.srst = SR_DELAY;
                    s_next.srcnt = 16'h0;
                    s_next.pend_w = wdt_bad;
                    s_next.pend_l = lv_bad;
                end
            end
            SR_DELAY: begin
                s_next.pend_w = s_reg.pend_w | wdt_bad;
                s_next.pend_l = s_reg.pend_l | lv_bad;
                if (s_reg.srcnt == 16'(SRESET_CYC - 16'h1)) begin
                    s_next.srst = SR_IDLE;
                    full_rst = 1'b1;
                    keep_lv = keep_lv && !s_next.pend_l;
                    s_next.wkf = s_next.wkf | s_next.pend_w;
                    s_next.lkf = s_next.lkf | s_next.pend_l;
                end else begin
                    s_next.srcnt = 16'(s_reg.srcnt + 16'h1);
                end
            end
        endcase

        // whole-device reset: pc to zero, ports back to inputs
        if (full_rst) begin
            s_next.dev_rst = 1'b1;
            s_next.pc_clr = 1'b1;
            s_next.port_pre = 1'b1;
            s_next.watchdog_control = WATCHDOG_CONTROL_POR;
            s_next.wcnt = 16'h0;
            s_next.srst = SR_IDLE;
            s_next.pend_w = 1'b0;
            s_next.pend_l = 1'b0;
            if (!keep_lv) begin
                s_next.low_voltage_control = LOW_VOLTAGE_CONTROL_POR;
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // power-on reset loads both keys with their enable patterns
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg <= ST_POR;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------
    assign wb_rsp.ack = s_reg.ack;
    assign wb_rsp.dat = s_reg.rdata;
    assign device_reset = s_reg.dev_rst;
    assign pc_sp_clear = s_reg.pc_clr;
    assign port_preset = s_reg.port_pre;
    assign timeout_status_flag = s_reg.to_flag;
    assign power_down_flag = s_reg.pd_flag;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_por_values: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> s_reg.watchdog_control == WATCHDOG_CONTROL_POR && s_reg.low_voltage_control == LOW_VOLTAGE_CONTROL_POR &&
            port_preset && pc_sp_clear ##1 !port_preset)
        else $error("power-on values wrong");

    a_key_fault_rst: assert property (@(posedge clk) disable iff (!rst_b)
        (s_reg.srst == SR_IDLE && wdt_bad && !s_next.dev_rst) |->
            ##[1:300] (device_reset && s_reg.wkf))
        else $error("bad watchdog key did not reset");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        (s_reg.wkf && !(bus_wr && wb_req.adr[3:2] == 2'b01)) |=> s_reg.wkf)
        else $error("key fault flag lost");

    a_flag_rsvd: assert property (@(posedge clk) disable iff (!rst_b)
        ($past(bus_req) && !$past(wb_req.we) && $past(wb_req.adr[3:2]) == 2'b01
            && wb_rsp.ack) |-> wb_rsp.dat[31:3] == 29'h0)
        else $error("flag register upper bits not zero");

    a_run_timeout: assert property (@(posedge clk) disable iff (!rst_b)
        (wdt_expire && !cpu.sleep) |=> device_reset && timeout_status_flag && port_preset)
        else $error("overflow did not reset device");

    a_sleep_timeout: assert property (@(posedge clk) disable iff (!rst_b)
        (wdt_expire && cpu.sleep && !s_next.dev_rst) |=>
            pc_sp_clear && !device_reset && timeout_status_flag)
        else $error("sleep overflow handled wrongly");

    a_wdt_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (cpu.clear_watchdog_instruction || cpu.halt) |=> s_reg.wcnt == 16'h0 ##1 s_reg.wcnt <= 16'h1)
        else $error("counter not cleared");

    a_wdt_limit: assert property (@(posedge clk) disable iff (!rst_b)
        wdt_expire |-> s_reg.wcnt == (16'hffff >> (5'd8 - 5'(s_reg.watchdog_control[2:0]))))
        else $error("timeout at wrong count");

    a_lv_filter: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(s_reg.lvf) |-> $past(s_reg.lvcnt) == LV_FILTER_CYCLES && device_reset)
        else $error("low-voltage reset without filter time");

    a_lv_sleep: assert property (@(posedge clk) disable iff (!rst_b)
        cpu.sleep [*2] |-> s_reg.lvcnt == 16'h0)
        else $error("supply monitor active in sleep");

    a_lv_keep: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(s_reg.lvf) && !$rose(s_reg.lkf) && !$past(bus_wr)) |-> $stable(s_reg.low_voltage_control))
        else $error("lv register changed on supply reset");

    a_wdt_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (wkey == WKEY_OFF) [*2] |-> s_reg.wcnt == 16'h0)
        else $error("disabled watchdog counted");

endmodule

// ===== sim/test_wrc_top.sv
// Purpose: self-checking bench for the watchdog and reset control block
// Assumes: short supply filter (20 cycles), slow oscillator ticks every 4 clocks
// Notes: register table first, then hand-written timeout, sleep, supply and key cases
`timescale 1ns/10ps

module test_wrc_top
    import wrc_pkg::*;
;
    // ----------------------------------------
    // signals and bookkeeping
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] adr; // register offset
        logic [7:0] wdat; // byte written first
        logic [7:0] exp; // byte expected on read back
    } wrc_tb_row_t;

    logic clk; // 200 MHz
    logic rst_b; // power-on reset, low active
    logic slow_osc_clock; // stands still between ticks
    logic lv_low; // supply below threshold
    wrc_cpu_t cpu; // instruction strobes and sleep level
    wrc_wb_req_t wb_req;
    wrc_wb_rsp_t wb_rsp;
    logic device_reset;
    logic pc_sp_clear;
    logic port_preset;
    logic timeout_status_flag;
    logic power_down_flag;
    int fails = 0; // mismatches
    int n_compared = 0; // comparisons made
    int cycles = 0; // hang guard
    int n_rst = 0; // device_reset pulses seen
    int n_pcs = 0; // pc_sp_clear pulses seen
    int n_pp = 0; // port_preset pulses seen
    logic mon_on = 1'b0; // pulse counting starts after reset

    // table rows: status writes are ignored, so a status row expects the status bits, not its written byte
    wrc_tb_row_t rows [8] = '{
        '{OFS_FLAGS, 8'hff, 8'h00}, '{OFS_WATCHDOG_CONTROL, 8'ha8, 8'ha8}, '{OFS_STAT, 8'hff, 8'h08},
        '{OFS_LOW_VOLTAGE_CONTROL, 8'ha5, 8'ha5}, '{OFS_STAT, 8'hff, 8'h00}, '{OFS_LOW_VOLTAGE_CONTROL, 8'h5a, 8'h5a},
        '{OFS_WATCHDOG_CONTROL, 8'h50, 8'h50}, '{OFS_STAT, 8'h00, 8'h0c}};

    // ----------------------------------------
    // clock, device and monitors
    // ----------------------------------------
    // free-running clock
    always begin
        #2.5 clk = ~clk;
    end

    wrc_top #(.LV_FILTER_CYCLES(16'd20)) dut_u (
        .clk(clk),
        .rst_b(rst_b),
        .slow_osc_clock(slow_osc_clock),
        .lv_low(lv_low),
        .cpu(cpu),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp),
        .device_reset(device_reset),
        .pc_sp_clear(pc_sp_clear),
        .port_preset(port_preset),
        .timeout_status_flag(timeout_status_flag),
        .power_down_flag(power_down_flag)
    );

    // count one-cycle pulses; the ceiling cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (mon_on) begin
            if (device_reset === 1'b1) n_rst++;
            if (pc_sp_clear === 1'b1) n_pcs++;
            if (port_preset === 1'b1) n_pp++;
        end
        if (cycles == 80000) begin
            fails++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled high
    // no local wait limit: only the cycle ceiling ends a hung request
    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: {24'h0, d}};
        do begin
            @(posedge clk);
        end while (wb_rsp.ack !== 1'b1);
        q = wb_rsp.dat;
        wb_req <= '0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        wb(1'b0, a, 8'h00, q);
    endtask

    // slow oscillator ticks, two clocks high and two low
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (2) @(posedge clk);
            slow_osc_clock <= 1'b1;
            repeat (2) @(posedge clk);
            slow_osc_clock <= 1'b0;
        end
    endtask

    // one-cycle instruction strobe: halt when h, else clear-watchdog
    task automatic strobe(input logic h);
        @(posedge clk);
        if (h) cpu.halt <= 1'b1;
        else cpu.clear_watchdog_instruction <= 1'b1;
        @(posedge clk);
        cpu.halt <= 1'b0;
        cpu.clear_watchdog_instruction <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // no overflow one tick short of n, overflow on tick n
    task automatic expect_overflow(input int n, input logic asleep);
        int r0;
        int c0;
        int p0;
        r0 = n_rst;
        c0 = n_pcs;
        p0 = n_pp;
        ticks(n - 1);
        repeat (6) @(posedge clk);
        check(n_pcs - c0, 0);
        ticks(1);
        repeat (6) @(posedge clk);
        check(n_rst - r0, asleep ? 0 : 1);
        check(n_pp - p0, asleep ? 0 : 1);
        check(n_pcs - c0, 1);
        check(timeout_status_flag, 1);
    endtask

    // supply dip of n clocks at the pin
    task automatic dip(input int n);
        @(posedge clk);
        lv_low <= 1'b1;
        repeat (n) @(posedge clk);
        lv_low <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // the only place the run ends
    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] q;
        int r0;
        clk = 1'b0;
        rst_b = 1'b0;
        slow_osc_clock = 1'b0;
        lv_low = 1'b0;
        cpu = '0;
        wb_req = '0;
        repeat (2) @(posedge clk);
        check(pc_sp_clear, 1);
        check(port_preset, 1);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        mon_on <= 1'b1;
        rd(OFS_WATCHDOG_CONTROL, q); check(q, 32'h53);
        rd(OFS_LOW_VOLTAGE_CONTROL, q); check(q, 32'h5a);
        // register table
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wdat);
            rd(rows[i].adr, q); check(q, {24'h0, rows[i].exp});
        end
        // without oscillator ticks the counter must not move, however long
        repeat (1500) @(posedge clk);
        check(n_rst, 0);
        // clear part-way restarts the full timeout
        ticks(200);
        strobe(1'b0);
        expect_overflow(256, 1'b0);
        // disabled counter holds zero, re-enable counts from zero
        wr(OFS_WATCHDOG_CONTROL, {WKEY_OFF, 3'h0});
        ticks(300);
        check(n_rst, 1);
        wr(OFS_WATCHDOG_CONTROL, {WKEY_ON, 3'h0});
        expect_overflow(256, 1'b0);
        // timeout codes; a full reset reloads the control register
        for (int s = 0; s < 5; s++) begin
            wr(OFS_WATCHDOG_CONTROL, {WKEY_ON, 3'(s)});
            strobe(1'b0);
            check(timeout_status_flag, 0);
            expect_overflow(1 << (WSEL_BASE + s), 1'b0);
            rd(OFS_WATCHDOG_CONTROL, q); check(q, 32'h53);
        end
        // halt part-way, then a sleeping overflow
        wr(OFS_WATCHDOG_CONTROL, {WKEY_ON, 3'h0});
        ticks(100);
        strobe(1'b1);
        cpu.sleep <= 1'b1;
        check(power_down_flag, 1);
        expect_overflow(256, 1'b1);
        rd(OFS_STAT, q); check(q & 32'h3, 32'h3);
        // supply monitor suspended while asleep
        r0 = n_rst;
        dip(40);
        check(n_rst - r0, 0);
        cpu.sleep <= 1'b0;
        strobe(1'b0);
        check(power_down_flag, 0);
        // filter boundary, flag, register kept
        dip(20);
        check(n_rst - r0, 0);
        dip(21);
        check(n_rst - r0, 1);
        rd(OFS_FLAGS, q); check(q, 32'h04);
        rd(OFS_LOW_VOLTAGE_CONTROL, q); check(q, 32'h5a);
        wr(OFS_FLAGS, 8'hfb);
        rd(OFS_FLAGS, q); check(q, 32'h00);
        wr(OFS_LOW_VOLTAGE_CONTROL, LV_KEY_OFF);
        dip(40);
        check(n_rst - r0, 1);
        wr(OFS_LOW_VOLTAGE_CONTROL, LV_KEY_ON);
        // bad keys: reset after the delay, sticky flag, power-on contents back
        for (int f = 0; f < 2; f++) begin
            r0 = n_rst;
            wr(f ? OFS_LOW_VOLTAGE_CONTROL : OFS_WATCHDOG_CONTROL, f ? 8'h33 : 8'h03);
            repeat (190) @(posedge clk);
            check(n_rst - r0, 0);
            repeat (20) @(posedge clk);
            check(n_rst - r0, 1);
            rd(OFS_FLAGS, q); check(q, 32'(1 << f));
            rd(f ? OFS_LOW_VOLTAGE_CONTROL : OFS_WATCHDOG_CONTROL, q); check(q, f ? 32'h5a : 32'h53);
            wr(OFS_FLAGS, 8'h00);
            rd(OFS_FLAGS, q); check(q, 32'h00);
        end
        report_and_stop();
    end

endmodule
